/* File: verilog/pgl_top.sv */
// board glue: address decode, access timing, video port, irq routing
//
// Contract
// - video logic acts only on accesses decoded to the user segment
// - address bits 23..20 steer user accesses to bitmap buffer or engine
// - bus machine raises host waiting flag when idle and awaiting user reply
// - external acknowledge is given only while host waiting flag is high
// - 8-bit engine command register holds until the next write
// - engine status is read through a read-only input path
// - writes to the bitmap range are stored in the page bitmap buffer
// - oscillator divided by eight gives the engine sync clock
// - video bits shift out only on engine data requests
// - irq slots take buffer empty, tick, video request in that order
// - video req->sync0, empty->sync2, parallel->3, tick->4, serial->5
// - dram: read 5, burst 5 then 2, write 5, page 4, precharge 2
// - boot rom: read 5, burst 5 then 4 for the other three words
// - serial segment decode ignores low address bits
// - every irq pin passes a bus clock synchroniser; buffer empty comes from bus clock logic
module pgl_top (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_bus_req,
  input wire pgl_pkg::bus_req_type i_bus,
  input wire logic [7:0] i_engine_status,
  input wire pgl_pkg::irq_src_type i_irq_pins,
  input wire logic i_engine_data_req,
  input wire logic i_osc_clk,
  output logic o_bus_ack,
  output logic o_bus_busy,
  output logic [31:0] o_bus_rdata,
  output pgl_pkg::sel_type o_dev_sel,
  output logic o_host_waiting_flag,
  output logic o_external_acknowledge,
  output logic [7:0] o_engine_cmd,
  output logic o_video_data,
  output logic o_engine_sync_clk,
  output pgl_pkg::cpu_irq_type o_cpu_irq
);
  //////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [pgl_pkg::PIN_W-1:0] pin_raw;
  logic [pgl_pkg::PIN_W-1:0] pin_meta_ff;
  logic [pgl_pkg::PIN_W-1:0] pin_sync_ff;
  logic dreq_prev_ff;
  logic osc_prev_ff;
  logic dreq_edge;
  logic osc_edge;
  logic [7:0] status_sync;
  pgl_pkg::irq_src_type irq_sync;

  assign pin_raw = {i_engine_status, i_irq_pins, i_engine_data_req,
                    i_osc_clk};

  // two flops per pin, the first read by nothing else
  genvar g;
  generate
    for (g = 0; g < pgl_pkg::PIN_W; g++) begin : g_sync
      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          pin_meta_ff[g] <= 1'b0;
          pin_sync_ff[g] <= 1'b0;
        end else begin
          pin_meta_ff[g] <= pin_raw[g];
          pin_sync_ff[g] <= pin_meta_ff[g];
        end
      end
    end
  endgenerate

  // edge history for the request and oscillator lines
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dreq_prev_ff <= 1'b0;
      osc_prev_ff <= 1'b0;
    end else begin
      dreq_prev_ff <= pin_sync_ff[pgl_pkg::PIN_DREQ];
      osc_prev_ff <= pin_sync_ff[pgl_pkg::PIN_OSC];
    end
  end

  assign dreq_edge = pin_sync_ff[pgl_pkg::PIN_DREQ] & ~dreq_prev_ff;
  assign osc_edge = pin_sync_ff[pgl_pkg::PIN_OSC] & ~osc_prev_ff;
  assign status_sync = pin_sync_ff[pgl_pkg::PIN_ST_HI:pgl_pkg::PIN_ST_LO];
  assign irq_sync = pin_sync_ff[pgl_pkg::PIN_IRQ_HI:pgl_pkg::PIN_IRQ_LO];

  //////////////////////////////////////////////////////////////////////
  // address decode
  logic [11:0] seg;
  logic [3:0] sub;
  logic dec_dram;
  logic dec_rom;
  logic dec_par;
  logic dec_ser;
  logic dec_user;

  assign seg = i_bus.addr[pgl_pkg::SEG_HI:pgl_pkg::SEG_LO];
  assign sub = i_bus.addr[pgl_pkg::SUB_HI:pgl_pkg::SUB_LO];
  assign dec_dram = (i_bus.addr[pgl_pkg::DRAM_HI:pgl_pkg::DRAM_LO] == '0);
  assign dec_rom = (seg == pgl_pkg::SEG_ROM0) | (seg == pgl_pkg::SEG_ROM1);
  assign dec_par = (seg == pgl_pkg::SEG_PAR);
  // peripheral decodes its own low bits
  assign dec_ser = (seg == pgl_pkg::SEG_SER);
  assign dec_user = (i_bus.addr[pgl_pkg::USER_HI:pgl_pkg::USER_LO] ==
                     pgl_pkg::USER_TOP) &
                    ((sub == pgl_pkg::SUB_FIFO0) |
                     (sub == pgl_pkg::SUB_FIFO1) |
                     (sub == pgl_pkg::SUB_SPARE) |
                     (sub == pgl_pkg::SUB_ENGINE));

  //////////////////////////////////////////////////////////////////////
  // main bus state machine
  pgl_pkg::bus_state_type state_ff;
  pgl_pkg::bus_state_type nxt_state;
  pgl_pkg::bus_req_type req_ff;
  pgl_pkg::bus_req_type nxt_req;
  pgl_pkg::sel_type sel_ff;
  pgl_pkg::sel_type nxt_sel;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic [1:0] word_ff;
  logic [1:0] nxt_word;
  logic burst_ff;
  logic nxt_burst;
  logic ack_ff;
  logic nxt_ack;
  logic wait_ff;
  logic nxt_wait;
  logic busy_ff;
  logic nxt_busy;
  logic ext_ack_ff;
  logic [3:0] lat;

  // requests are taken only in idle; a dram access ends in precharge
  always_comb begin
    nxt_state = state_ff;
    nxt_req = req_ff;
    nxt_sel = sel_ff;
    nxt_cnt = cnt_ff;
    nxt_word = word_ff;
    nxt_burst = burst_ff;
    nxt_ack = 1'b0;
    nxt_wait = wait_ff;
    lat = pgl_pkg::UNMAPPED_CYC;
    case (state_ff)
      pgl_pkg::ST_IDLE: begin
        if (i_bus_req) begin
          nxt_req = i_bus;
          nxt_word = 2'h0;
          nxt_sel = '0;
          nxt_burst = i_bus.burst & ~i_bus.wr & (dec_dram | dec_rom);
          nxt_state = pgl_pkg::ST_MEM;
          if (dec_user) begin
            nxt_sel.user = 1'b1;
            nxt_state = pgl_pkg::ST_USER;
            nxt_wait = 1'b1;
          end else if (dec_dram) begin
            nxt_sel.dram = 1'b1;
            if (!i_bus.wr) begin
              lat = pgl_pkg::DRAM_RD_CYC;
            end else if (i_bus.page) begin
              lat = pgl_pkg::DRAM_PAGE_CYC;
            end else begin
              lat = pgl_pkg::DRAM_WR_CYC;
            end
          end else if (dec_rom) begin
            nxt_sel.rom = 1'b1;
            lat = pgl_pkg::ROM_RD_CYC;
          end else if (dec_par) begin
            nxt_sel.par = 1'b1;
            lat = pgl_pkg::PERIPH_CYC;
          end else if (dec_ser) begin
            nxt_sel.ser = 1'b1;
            lat = pgl_pkg::PERIPH_CYC;
          end
          nxt_cnt = lat - 4'h1;
        end
      end
      pgl_pkg::ST_MEM: begin
        if (cnt_ff == 4'h0) begin
          nxt_ack = 1'b1;
          if (burst_ff && word_ff != pgl_pkg::LAST_WORD) begin
            nxt_word = word_ff + 2'h1;
            nxt_cnt = (sel_ff.rom ? pgl_pkg::ROM_NEXT_CYC
                                  : pgl_pkg::DRAM_NEXT_CYC) - 4'h1;
          end else if (sel_ff.dram) begin
            nxt_sel = '0;
            nxt_cnt = pgl_pkg::DRAM_PRECHG_CYC - 4'h1;
            nxt_state = pgl_pkg::ST_PRECHG;
          end else begin
            nxt_sel = '0;
            nxt_state = pgl_pkg::ST_IDLE;
          end
        end else begin
          nxt_cnt = cnt_ff - 4'h1;
        end
      end
      pgl_pkg::ST_USER: begin
        // the video side answers only while the flag is up
        if (ext_ack_ff) begin
          nxt_ack = 1'b1;
          nxt_wait = 1'b0;
          nxt_sel = '0;
          nxt_state = pgl_pkg::ST_IDLE;
        end
      end
      pgl_pkg::ST_PRECHG: begin
        if (cnt_ff == 4'h0) begin
          nxt_state = pgl_pkg::ST_IDLE;
        end else begin
          nxt_cnt = cnt_ff - 4'h1;
        end
      end
      default: begin
        nxt_state = pgl_pkg::ST_IDLE;
        nxt_sel = '0;
        nxt_wait = 1'b0;
      end
    endcase
    nxt_busy = (nxt_state != pgl_pkg::ST_IDLE);
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_ff <= pgl_pkg::ST_IDLE;
      req_ff <= '0;
      sel_ff <= '0;
      cnt_ff <= 4'h0;
      word_ff <= 2'h0;
      burst_ff <= 1'b0;
      ack_ff <= 1'b0;
      wait_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      req_ff <= nxt_req;
      sel_ff <= nxt_sel;
      cnt_ff <= nxt_cnt;
      word_ff <= nxt_word;
      burst_ff <= nxt_burst;
      ack_ff <= nxt_ack;
      wait_ff <= nxt_wait;
      busy_ff <= nxt_busy;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // video interface: engine port and bitmap buffer writes
  pgl_pkg::vid_state_type vst_ff;
  pgl_pkg::vid_state_type nxt_vst;
  logic nxt_ext_ack;
  logic [7:0] cmd_ff;
  logic [7:0] nxt_cmd;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [3:0] vsub;
  logic buf_in_valid;
  logic buf_in_ready;

  assign vsub = req_ff.addr[pgl_pkg::SUB_HI:pgl_pkg::SUB_LO];

  // a buffer write waits for room, stalling the bus reply
  always_comb begin
    nxt_vst = vst_ff;
    nxt_ext_ack = 1'b0;
    nxt_cmd = cmd_ff;
    nxt_rdata = rdata_ff;
    buf_in_valid = 1'b0;
    case (vst_ff)
      pgl_pkg::V_IDLE: begin
        if (wait_ff && sel_ff.user) begin
          if (vsub == pgl_pkg::SUB_FIFO0 || vsub == pgl_pkg::SUB_FIFO1) begin
            nxt_rdata = '0;
            if (req_ff.wr) begin
              buf_in_valid = 1'b1;
              if (buf_in_ready) begin
                nxt_ext_ack = 1'b1;
                nxt_vst = pgl_pkg::V_DONE;
              end
            end else begin
              nxt_ext_ack = 1'b1;
              nxt_vst = pgl_pkg::V_DONE;
            end
          end else if (vsub == pgl_pkg::SUB_ENGINE) begin
            if (req_ff.wr) begin
              nxt_cmd = req_ff.wdata[pgl_pkg::CMD_W-1:0];
            end else begin
              nxt_rdata = {24'h00_0000, status_sync};
            end
            nxt_ext_ack = 1'b1;
            nxt_vst = pgl_pkg::V_DONE;
          end else begin
            nxt_rdata = '0;
            nxt_ext_ack = 1'b1;
            nxt_vst = pgl_pkg::V_DONE;
          end
        end
      end
      pgl_pkg::V_DONE: begin
        // rearm only after the bus machine drops the flag
        if (!wait_ff) begin
          nxt_vst = pgl_pkg::V_IDLE;
        end
      end
      default: begin
        nxt_vst = pgl_pkg::V_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      vst_ff <= pgl_pkg::V_IDLE;
      ext_ack_ff <= 1'b0;
      cmd_ff <= pgl_pkg::CMD_RST;
      rdata_ff <= '0;
    end else begin
      vst_ff <= nxt_vst;
      ext_ack_ff <= nxt_ext_ack;
      cmd_ff <= nxt_cmd;
      rdata_ff <= nxt_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // bitmap buffer and serialiser toward the engine
  logic buf_out_valid;
  logic buf_out_ready;
  logic [31:0] buf_out_data;
  logic [31:0] shift_ff;
  logic [31:0] nxt_shift;
  logic [5:0] bits_ff;
  logic [5:0] nxt_bits;
  logic vdata_ff;
  logic nxt_vdata;
  logic empty_now;

  pgl_pair_buf u_buf (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_in_valid(buf_in_valid),
    .o_in_ready(buf_in_ready),
    .i_in_data(req_ff.wdata),
    .o_out_valid(buf_out_valid),
    .i_out_ready(buf_out_ready),
    .o_out_data(buf_out_data)
  );

  // refill only when the shifter has run dry
  assign buf_out_ready = (bits_ff == 6'h00);
  assign empty_now = ~buf_out_valid & (bits_ff == 6'h00);

  always_comb begin
    nxt_shift = shift_ff;
    nxt_bits = bits_ff;
    nxt_vdata = vdata_ff;
    if (buf_out_valid && buf_out_ready) begin
      nxt_shift = buf_out_data;
      nxt_bits = pgl_pkg::SHIFT_BITS;
    end else if (dreq_edge && bits_ff != 6'h00) begin
      nxt_vdata = shift_ff[pgl_pkg::WORD_W-1];
      nxt_shift = {shift_ff[pgl_pkg::WORD_W-2:0], 1'b0};
      nxt_bits = bits_ff - 6'h01;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      shift_ff <= '0;
      bits_ff <= 6'h00;
      vdata_ff <= 1'b0;
    end else begin
      shift_ff <= nxt_shift;
      bits_ff <= nxt_bits;
      vdata_ff <= nxt_vdata;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // engine sync clock: toggle every four oscillator edges
  logic [1:0] div_ff;
  logic [1:0] nxt_div;
  logic sclk_ff;
  logic nxt_sclk;

  always_comb begin
    nxt_div = div_ff;
    nxt_sclk = sclk_ff;
    if (osc_edge) begin
      if (div_ff == pgl_pkg::SYNC_HALF_MAX) begin
        nxt_div = 2'h0;
        nxt_sclk = ~sclk_ff;
      end else begin
        nxt_div = div_ff + 2'h1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_ff <= 2'h0;
      sclk_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      sclk_ff <= nxt_sclk;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // interrupt slots and routing to the processor inputs
  logic [2:0] irq_slot;
  pgl_pkg::cpu_irq_type irq_ff;
  pgl_pkg::cpu_irq_type nxt_irq;

  // slot 0 empty, slot 1 tick, slot 2 video request
  assign irq_slot = {irq_sync.video_req, irq_sync.tick, empty_now};

  always_comb begin
    nxt_irq.sync0 = irq_slot[2];
    nxt_irq.sync2 = irq_slot[0];
    nxt_irq.irq3 = irq_sync.par_full;
    nxt_irq.irq4 = irq_slot[1];
    nxt_irq.irq5 = irq_sync.serial;
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_ff <= '0;
    end else begin
      irq_ff <= nxt_irq;
    end
  end

  // every output straight from a flop
  assign o_bus_ack = ack_ff;
  assign o_bus_busy = busy_ff;
  assign o_bus_rdata = rdata_ff;
  assign o_dev_sel = sel_ff;
  assign o_host_waiting_flag = wait_ff;
  assign o_external_acknowledge = ext_ack_ff;
  assign o_engine_cmd = cmd_ff;
  assign o_video_data = vdata_ff;
  assign o_engine_sync_clk = sclk_ff;
  assign o_cpu_irq = irq_ff;

  //////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  logic take;
  assign take = i_bus_req & (state_ff == pgl_pkg::ST_IDLE);

  AST_USER_ONLY: assert property (
    ext_ack_ff |-> sel_ff.user)
    else $error("video answered outside user segment");
  AST_ENGINE_WR: assert property (
    take && dec_user && i_bus.wr && sub == pgl_pkg::SUB_ENGINE
    |-> ##3 o_engine_cmd == $past(i_bus.wdata[pgl_pkg::CMD_W-1:0], 3))
    else $error("engine write did not reach command register");
  AST_WAIT_SET: assert property (
    take && dec_user |=> wait_ff && state_ff == pgl_pkg::ST_USER)
    else $error("host waiting flag not raised");
  AST_ACK_IN_WAIT: assert property (
    ext_ack_ff |-> wait_ff ##1 (ack_ff && !wait_ff))
    else $error("acknowledge without waiting flag");
  AST_CMD_HOLD: assert property (
    !(vst_ff == pgl_pkg::V_IDLE && wait_ff) |=> $stable(o_engine_cmd))
    else $error("command register changed without write");
  AST_STATUS_RD: assert property (
    vst_ff == pgl_pkg::V_IDLE && wait_ff && !req_ff.wr &&
    vsub == pgl_pkg::SUB_ENGINE |=> o_bus_rdata[7:0] == $past(status_sync))
    else $error("status read mismatch");
  AST_FIFO_STALL: assert property (
    buf_in_valid && !buf_in_ready |=> !ext_ack_ff)
    else $error("buffer write acknowledged while full");
  AST_SYNC_DIV: assert property (
    $changed(o_engine_sync_clk) |-> $past(osc_edge) && div_ff == 2'h0)
    else $error("sync clock toggled off the divide point");
  AST_SHIFT_REQ: assert property (
    $changed(bits_ff) && bits_ff != pgl_pkg::SHIFT_BITS |-> $past(dreq_edge))
    else $error("video bit shifted without request");
  AST_ROUTE: assert property (
    o_cpu_irq.sync0 == $past(irq_sync.video_req) &&
    o_cpu_irq.irq4 == $past(irq_sync.tick))
    else $error("interrupt routing wrong");
  AST_DRAM_RD: assert property (
    take && !dec_user && dec_dram && !i_bus.wr && !i_bus.burst
    |=> !ack_ff [*5] ##1 ack_ff ##1 busy_ff ##1 !busy_ff)
    else $error("dram read timing wrong");
  AST_ROM_BURST: assert property (
    take && !dec_user && !dec_dram && dec_rom && i_bus.burst && !i_bus.wr
    |-> ##6 ack_ff ##4 ack_ff ##4 ack_ff ##4 ack_ff)
    else $error("rom burst timing wrong");
  AST_SER_DEC: assert property (
    take && seg == pgl_pkg::SEG_SER |=> o_dev_sel.ser)
    else $error("serial segment missed");
  AST_EMPTY_IRQ: assert property (
    empty_now |=> o_cpu_irq.sync2)
    else $error("empty irq not shown");

  COV_DRAM_BURST: cover property (take && dec_dram && i_bus.burst);
  COV_ENGINE_WR: cover property (ext_ack_ff && req_ff.wr &&
    vsub == pgl_pkg::SUB_ENGINE);
  COV_BUF_FULL: cover property (buf_in_valid && !buf_in_ready);
endmodule

/* File: verilog/pgl_pkg.sv */
// shared constants, types and states of the printer glue logic
package pgl_pkg;
  // bus clock cycle counts of each memory access kind
  localparam logic [3:0] DRAM_RD_CYC = 4'h5;
  localparam logic [3:0] DRAM_NEXT_CYC = 4'h2;
  localparam logic [3:0] DRAM_WR_CYC = 4'h5;
  localparam logic [3:0] DRAM_PAGE_CYC = 4'h4;
  localparam logic [3:0] DRAM_PRECHG_CYC = 4'h2;
  localparam logic [3:0] ROM_RD_CYC = 4'h5;
  localparam logic [3:0] ROM_NEXT_CYC = 4'h4;
  localparam logic [3:0] PERIPH_CYC = 4'h4;
  localparam logic [3:0] UNMAPPED_CYC = 4'h1;
  localparam logic [1:0] LAST_WORD = 2'h3;
  // address field positions
  localparam int SEG_HI = 31;
  localparam int SEG_LO = 20;
  localparam int SUB_HI = 23;
  localparam int SUB_LO = 20;
  localparam int DRAM_HI = 29;
  localparam int DRAM_LO = 22;
  localparam int USER_HI = 31;
  localparam int USER_LO = 24;
  // segment codes on address bits 31..20, user top code on bits 31..24
  localparam logic [11:0] SEG_PAR = 12'h006;
  localparam logic [11:0] SEG_SER = 12'h00A;
  localparam logic [11:0] SEG_ROM0 = 12'h1FC;
  localparam logic [11:0] SEG_ROM1 = 12'h1FD;
  localparam logic [7:0] USER_TOP = 8'h00;
  // sub ranges of the user segment on bits 23..20
  localparam logic [3:0] SUB_FIFO0 = 4'h4;
  localparam logic [3:0] SUB_FIFO1 = 4'h5;
  localparam logic [3:0] SUB_SPARE = 4'h8;
  localparam logic [3:0] SUB_ENGINE = 4'h9;
  // engine side
  localparam int CMD_W = 8;
  localparam int WORD_W = 32;
  localparam logic [5:0] SHIFT_BITS = 6'h20;
  localparam int SYNC_DIV = 8;
  localparam logic [1:0] SYNC_HALF_MAX = 2'(SYNC_DIV / 2 - 1);
  localparam logic [7:0] CMD_RST = 8'h00;
  // pin synchroniser bit positions
  localparam int PIN_W = 14;
  localparam int PIN_OSC = 0;
  localparam int PIN_DREQ = 1;
  localparam int PIN_IRQ_LO = 2;
  localparam int PIN_IRQ_HI = 5;
  localparam int PIN_ST_LO = 6;
  localparam int PIN_ST_HI = 13;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic burst;
    logic page;
  } bus_req_type;

  typedef struct packed {
    logic dram;
    logic rom;
    logic par;
    logic ser;
    logic user;
  } sel_type;

  typedef struct packed {
    logic video_req;
    logic tick;
    logic par_full;
    logic serial;
  } irq_src_type;

  typedef struct packed {
    logic sync0;
    logic sync2;
    logic irq3;
    logic irq4;
    logic irq5;
  } cpu_irq_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MEM = 2'b01,
    ST_USER = 2'b10,
    ST_PRECHG = 2'b11
  } bus_state_type;

  typedef enum logic {
    V_IDLE = 1'b0,
    V_DONE = 1'b1
  } vid_state_type;
endpackage

/* File: verilog/pgl_pair_buf.sv */
// two-entry buffer with valid and ready on both sides
module pgl_pair_buf (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [31:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [31:0] o_out_data
);
  logic [31:0] mem_ff [2];
  logic [31:0] nxt_mem [2];
  logic [1:0] cnt_ff;
  logic [1:0] nxt_cnt;
  logic wp_ff;
  logic nxt_wp;
  logic rp_ff;
  logic nxt_rp;
  logic push;
  logic pop;

  // full at two words, so a stalled reader pushes back on the writer
  assign o_in_ready = (cnt_ff != 2'h2);
  assign o_out_valid = (cnt_ff != 2'h0);
  assign o_out_data = mem_ff[rp_ff];
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  // pointer and storage update
  always_comb begin
    nxt_mem = mem_ff;
    nxt_cnt = cnt_ff + 2'(push) - 2'(pop);
    nxt_wp = wp_ff ^ push;
    nxt_rp = rp_ff ^ pop;
    if (push) begin
      nxt_mem[wp_ff] = i_in_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mem_ff[0] <= 32'h0000_0000;
      mem_ff[1] <= 32'h0000_0000;
      cnt_ff <= 2'h0;
      wp_ff <= 1'b0;
      rp_ff <= 1'b0;
    end else begin
      mem_ff <= nxt_mem;
      cnt_ff <= nxt_cnt;
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
    end
  end
endmodule

/* File: testbench/pgl_engine_model.sv */
// print engine model: oscillator, status pins, data requests
module pgl_engine_model (
  output logic o_osc_clk,
  output logic o_data_req,
  output logic [7:0] o_status,
  input wire logic i_video_data
);
  timeunit 1ns;
  timeprecision 1ps;
  parameter real OSC_HALF = 33.535;
  logic [7:0] status = 8'h00;
  ////////////////////////////////////////////////////////////////////////
  // free running oscillator, engine owns it
  initial begin
    o_osc_clk = 1'b0;
    forever #(OSC_HALF) o_osc_clk = ~o_osc_clk;
  end
  assign o_status = status;
  initial o_data_req = 1'b0;
  ////////////////////////////////////////////////////////////////////////
  // one request edge per bit; slow enough for the two-flop sync
  task automatic pull(output logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      #40 o_data_req = 1'b1;
      #40 o_data_req = 1'b0;
      w[i] = i_video_data; // msb arrives first
    end
  endtask
endmodule

/* File: testbench/pgl_top_tb_top.sv */
// self-checking bench for the printer glue logic
module pgl_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_arst_n, i_bus_req, i_engine_data_req, i_osc_clk;
  pgl_pkg::bus_req_type i_bus;
  logic [7:0] i_engine_status;
  pgl_pkg::irq_src_type i_irq_pins;
  logic o_bus_ack, o_bus_busy, o_host_waiting_flag, o_external_acknowledge;
  logic o_video_data, o_engine_sync_clk;
  logic [31:0] o_bus_rdata;
  logic [7:0] o_engine_cmd;
  pgl_pkg::sel_type o_dev_sel;
  pgl_pkg::cpu_irq_type o_cpu_irq;
  int n_mismatch = 0;
  int tests_run = 0;
  int lat, gap, wf, xa;
  logic [4:0] sel;
  logic [31:0] rd, w, d;
  logic [31:0] q [4];
  realtime t0;
  // access table: address, {wr,burst,page}, latency, burst gap, select
  logic [31:0] t_a [9] = '{32'h00001000, 32'h003FFFF0, 32'h00000040,
    32'h00000100, 32'h1FC00000, 32'h1FD00010, 32'h00A0003C, 32'h00600000,
    32'h0B000000};
  logic [2:0] t_c [9] = '{3'h0, 3'h4, 3'h5, 3'h2, 3'h0, 3'h2, 3'h0, 3'h0, 3'h0};
  int t_l [9] = '{5, 5, 4, 5, 5, 5, 4, 4, 1};
  int t_g [9] = '{0, 0, 0, 2, 0, 4, 0, 0, 0};
  logic [4:0] t_s [9] = '{5'h10, 5'h10, 5'h10, 5'h10, 5'h08, 5'h08, 5'h02,
    5'h04, 5'h00};

  pgl_top u_pgl_top (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_bus_req(i_bus_req), .i_bus(i_bus), .i_engine_status(i_engine_status),
    .i_irq_pins(i_irq_pins), .i_engine_data_req(i_engine_data_req),
    .i_osc_clk(i_osc_clk), .o_bus_ack(o_bus_ack), .o_bus_busy(o_bus_busy),
    .o_bus_rdata(o_bus_rdata), .o_dev_sel(o_dev_sel),
    .o_host_waiting_flag(o_host_waiting_flag),
    .o_external_acknowledge(o_external_acknowledge),
    .o_engine_cmd(o_engine_cmd), .o_video_data(o_video_data),
    .o_engine_sync_clk(o_engine_sync_clk), .o_cpu_irq(o_cpu_irq));
  pgl_engine_model u_pgl_engine_model (.o_osc_clk(i_osc_clk),
    .o_data_req(i_engine_data_req), .o_status(i_engine_status),
    .i_video_data(o_video_data));
  ////////////////////////////////////////////////////////////////////////
  // 125 mhz bus clock
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (e !== g) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic end_sim();
    $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // processor irq bits sync0, irq3, irq4, irq5 expected from the pins
  function automatic logic [3:0] exp_irq(pgl_pkg::irq_src_type p);
    return {p.video_req, p.par_full, p.tick, p.serial};
  endfunction
  // one access; request held for the single taking edge only
  task automatic bus(logic [31:0] a, logic [31:0] dt, logic [2:0] c);
    i_bus = '{a, dt, c[2], c[1], c[0]};
    i_bus_req = 1'b1;
    @(negedge i_clk);
    i_bus_req = 1'b0;
    sel = o_dev_sel;
    wf = o_host_waiting_flag;
    xa = 0;
    lat = 0;
    gap = 0;
    // long limit: a bitmap write may stall until a whole word is shifted
    while (o_bus_ack !== 1'b1 && lat < 500) begin
      @(negedge i_clk);
      lat++;
      xa += o_external_acknowledge;
    end
    rd = o_bus_rdata;
    if (c[1]) begin
      @(negedge i_clk);
      gap = 1;
      while (o_bus_ack !== 1'b1 && gap < 60) begin
        @(negedge i_clk);
        gap++;
      end
    end
    for (int k = 0; k < 60 && o_bus_busy !== 1'b0; k++) @(negedge i_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    i_arst_n = 1'b0;
    i_bus_req = 1'b0;
    i_bus = '0;
    i_irq_pins = '0;
    void'($urandom(22));
    repeat (8) @(negedge i_clk);
    i_arst_n = 1'b1;
    repeat (4) @(negedge i_clk);
    chk("empty irq", 1, o_cpu_irq.sync2);
    for (int i = 0; i < 9; i++) begin
      bus(t_a[i], $urandom, t_c[i]);
      chk("latency", t_l[i], lat);
      chk("gap", t_g[i], gap);
      chk("select", t_s[i], sel);
      chk("video ack", 0, xa);
    end
    d = $urandom;
    bus(32'h00900000, d, 3'h4);
    chk("user latency", 2, lat);
    chk("user select", 5'h01, sel);
    chk("waiting flag", 1, wf);
    chk("ext ack", 1, xa);
    bus(32'h00800000, ~d, 3'h4);
    repeat (3) @(negedge i_clk);
    chk("command", d[7:0], o_engine_cmd);
    u_pgl_engine_model.status = 8'($urandom);
    repeat (5) @(negedge i_clk);
    bus(32'h00900000, 32'h0, 3'h0);
    chk("status", {24'h0, u_pgl_engine_model.status}, rd);
    d = $urandom;
    bus(32'h00400000, d, 3'h4);
    repeat (4) @(negedge i_clk);
    chk("empty cleared", 0, o_cpu_irq.sync2);
    u_pgl_engine_model.pull(w);
    chk("video word", d, w);
    repeat (5) @(negedge i_clk);
    chk("empty again", 1, o_cpu_irq.sync2);
    // shifter and buffer take three words; the fourth must wait for room
    for (int i = 0; i < 4; i++) q[i] = $urandom;
    for (int i = 0; i < 3; i++) bus(32'h00500000, q[i], 3'h4);
    fork
      bus(32'h00400000, q[3], 3'h4);
      for (int i = 0; i < 4; i++) begin
        u_pgl_engine_model.pull(w);
        chk("queued word", q[i], w);
      end
    join
    chk("stall", 1, lat > 60 && lat < 500);
    for (int i = 0; i < 4; i++) begin
      i_irq_pins = 4'(1 << i);
      repeat (5) @(negedge i_clk);
      chk("irq", exp_irq(i_irq_pins), {o_cpu_irq.sync0, o_cpu_irq.irq3,
        o_cpu_irq.irq4, o_cpu_irq.irq5});
    end
    @(posedge o_engine_sync_clk);
    t0 = $realtime;
    @(posedge o_engine_sync_clk);
    t0 = $realtime - t0;
    chk("sync period", 1, (t0 > 520.0 && t0 < 560.0));
    end_sim();
  end
  // watchdog well past the expected run of about fourteen microseconds
  initial begin
    #200000;
    n_mismatch++;
    end_sim();
  end
endmodule
